// >>> logic/sshp_defs.svh
// constants of the spi slave with pause control
`ifndef SSHP_DEFS_SVH
`define SSHP_DEFS_SVH

// serial word layout
`define SSHP_WORD_W 8
`define SSHP_CNT_W 3
`define SSHP_CNT_ZERO 3'h0
`define SSHP_CNT_ONE 3'h1
`define SSHP_LAST_BIT 3'h7
`define SSHP_MSB 7
`define SSHP_IDLE_WORD 8'hff
`define SSHP_ZERO_WORD 8'h00

// synchroniser depth
`define SSHP_SYNC_STAGES 3

`endif

// >>> logic/sshp_pkg.sv
// types of the spi slave with pause control
package sshp_pkg;

    // link state seen from the system clock
    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_active = 2'b01,
        st_paused = 2'b10,
        st_parked = 2'b11
    } sshp_link_t;

endpackage

// >>> logic/sshp_sync.sv
// three stage level synchroniser with agreement filter
`timescale 1ns/1ps
`include "sshp_defs.svh"

module sshp_sync
#(
    parameter logic INIT = 1'b0
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // level in and filtered level out
    input wire logic d,
    output logic q
);

    logic [`SSHP_SYNC_STAGES-1:0] stage_reg;
    logic q_reg;

    // ==========================================
    // shift chain
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            stage_reg <= {`SSHP_SYNC_STAGES{INIT}};
        end
        else
        begin
            stage_reg <= {stage_reg[`SSHP_SYNC_STAGES-2:0], d};
        end
    end

    // ==========================================
    // change counts once last two stages agree
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            q_reg <= INIT;
        end
        else if (stage_reg[`SSHP_SYNC_STAGES-1] ==
                 stage_reg[`SSHP_SYNC_STAGES-2])
        begin
            q_reg <= stage_reg[`SSHP_SYNC_STAGES-1];
        end
    end

    assign q = q_reg;

endmodule // sshp_sync

// >>> logic/sshp_top.sv
// spi slave serial engine with pause and suspend support
`timescale 1ns/1ps
`include "sshp_defs.svh"

// Notes on behaviour
// - pause freezes received bits, transmit word and bit position
// - clock edges during pause only advance the link side crossing synchronisers
// - data input ignored while paused
// - output enable dropped while paused, data output holds its last bit
// - deselect during pause keeps suspended sequence
// - reselect then release resumes kept sequence
module sshp_top
    import sshp_pkg::*;
(
    // system clock and reset
    input wire logic clk,
    input wire logic srst,
    // serial link pins
    input wire logic sck,
    input wire logic cs_n,
    input wire logic hold_n,
    input wire logic si,
    output logic so,
    output logic so_oe,
    // received words
    output logic [`SSHP_WORD_W-1:0] rx_data,
    output logic rx_valid,
    // words to send
    input wire logic [`SSHP_WORD_W-1:0] tx_data,
    input wire logic tx_load,
    output logic tx_ready,
    // link status
    output logic paused
);

    // ==========================================
    // declarations, system clock side
    sshp_link_t state_reg;
    sshp_link_t state_next;
    logic cs_n_q;
    logic hold_n_q;
    logic rx_tgl_q;
    logic tx_ack_q;
    logic abort_tgl_reg;
    logic rx_seen_reg;
    logic [`SSHP_WORD_W-1:0] rx_data_reg;
    logic rx_valid_reg;
    logic [`SSHP_WORD_W-1:0] tx_buf_reg;
    logic tx_req_tgl_reg;
    logic tx_ready_reg;
    logic so_oe_reg;
    logic paused_reg;

    // declarations, link clock side
    logic sck_rst;
    logic abort_q;
    logic tx_req_q;
    logic abort_seen_reg;
    logic [`SSHP_CNT_W-1:0] bit_cnt_reg;
    logic [`SSHP_WORD_W-1:0] rx_shift_reg;
    logic [`SSHP_WORD_W-1:0] rx_word_reg;
    logic rx_tgl_reg;
    logic [`SSHP_WORD_W-1:0] tx_shift_reg;
    logic tx_ack_tgl_reg;
    logic so_reg;
    logic shift_en;
    logic fresh;
    logic [`SSHP_CNT_W-1:0] cnt_base;
    logic [`SSHP_WORD_W-1:0] rx_base;

    // ==========================================
    // pin and crossing synchronisers, system side
    sshp_sync #(.INIT(1'b1)) u_sync_cs
    (
        .clk(clk),
        .rst(srst),
        .d(cs_n),
        .q(cs_n_q)
    );

    sshp_sync #(.INIT(1'b1)) u_sync_hold
    (
        .clk(clk),
        .rst(srst),
        .d(hold_n),
        .q(hold_n_q)
    );

    sshp_sync #(.INIT(1'b0)) u_sync_rx
    (
        .clk(clk),
        .rst(srst),
        .d(rx_tgl_reg),
        .q(rx_tgl_q)
    );

    sshp_sync #(.INIT(1'b0)) u_sync_ack
    (
        .clk(clk),
        .rst(srst),
        .d(tx_ack_tgl_reg),
        .q(tx_ack_q)
    );

    // ==========================================
    // crossing synchronisers, link side
    sshp_sync #(.INIT(1'b1)) u_sync_rst
    (
        .clk(sck),
        .rst(1'b0),
        .d(srst),
        .q(sck_rst)
    );

    sshp_sync #(.INIT(1'b0)) u_sync_abort
    (
        .clk(sck),
        .rst(sck_rst),
        .d(abort_tgl_reg),
        .q(abort_q)
    );

    sshp_sync #(.INIT(1'b0)) u_sync_txreq
    (
        .clk(sck),
        .rst(sck_rst),
        .d(tx_req_tgl_reg),
        .q(tx_req_q)
    );

    // ==========================================
    // link state tracking
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            st_idle:
            begin
                if (!cs_n_q)
                begin
                    state_next = hold_n_q ? st_active : st_paused;
                end
            end
            st_active:
            begin
                if (cs_n_q)
                begin
                    state_next = st_idle;
                end
                else if (!hold_n_q)
                begin
                    state_next = st_paused;
                end
            end
            st_paused:
            begin
                if (cs_n_q)
                begin
                    state_next = st_parked;
                end
                else if (hold_n_q)
                begin
                    state_next = st_active;
                end
            end
            st_parked:
            begin
                if (!cs_n_q)
                begin
                    state_next = hold_n_q ? st_active : st_paused;
                end
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_reg <= st_idle;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // deselect without pause restarts the sequence
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            abort_tgl_reg <= 1'b0;
        end
        else if (state_reg == st_active && state_next == st_idle)
        begin
            abort_tgl_reg <= ~abort_tgl_reg;
        end
    end

    // output enable only while selected and not paused
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            so_oe_reg <= 1'b0;
            paused_reg <= 1'b0;
        end
        else
        begin
            so_oe_reg <= (state_next == st_active);
            paused_reg <= (state_next == st_paused) ||
                          (state_next == st_parked);
        end
    end

    // ==========================================
    // received word handover
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            rx_seen_reg <= 1'b0;
            rx_data_reg <= `SSHP_ZERO_WORD;
            rx_valid_reg <= 1'b0;
        end
        else
        begin
            rx_valid_reg <= (rx_tgl_q != rx_seen_reg);
            if (rx_tgl_q != rx_seen_reg)
            begin
                rx_seen_reg <= rx_tgl_q;
                rx_data_reg <= rx_word_reg;
            end
        end
    end

    // ==========================================
    // transmit word handshake
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            tx_buf_reg <= `SSHP_IDLE_WORD;
            tx_req_tgl_reg <= 1'b0;
            tx_ready_reg <= 1'b0;
        end
        else if (tx_load && tx_ready_reg)
        begin
            tx_buf_reg <= tx_data;
            tx_req_tgl_reg <= ~tx_req_tgl_reg;
            tx_ready_reg <= 1'b0;
        end
        else
        begin
            tx_ready_reg <= (tx_ack_q == tx_req_tgl_reg);
        end
    end

    // ==========================================
    // link side shifting, rising edge
    // pause pin is steady at every edge since it moves with clock low
    assign shift_en = !cs_n && hold_n;
    assign fresh = (abort_q != abort_seen_reg);
    assign cnt_base = fresh ? `SSHP_CNT_ZERO : bit_cnt_reg;
    assign rx_base = fresh ? `SSHP_ZERO_WORD : rx_shift_reg;

    always_ff @(posedge sck)
    begin
        if (sck_rst)
        begin
            abort_seen_reg <= 1'b0;
            bit_cnt_reg <= `SSHP_CNT_ZERO;
            rx_shift_reg <= `SSHP_ZERO_WORD;
        end
        else if (shift_en)
        begin
            abort_seen_reg <= abort_q;
            bit_cnt_reg <= cnt_base + `SSHP_CNT_ONE;
            rx_shift_reg <= {rx_base[`SSHP_MSB-1:0], si};
        end
    end

    // word complete: hand to system side, fetch next transmit word
    always_ff @(posedge sck)
    begin
        if (sck_rst)
        begin
            rx_word_reg <= `SSHP_ZERO_WORD;
            rx_tgl_reg <= 1'b0;
            tx_shift_reg <= `SSHP_IDLE_WORD;
            tx_ack_tgl_reg <= 1'b0;
        end
        else if (shift_en && cnt_base == `SSHP_LAST_BIT)
        begin
            rx_word_reg <= {rx_base[`SSHP_MSB-1:0], si};
            rx_tgl_reg <= ~rx_tgl_reg;
            if (tx_req_q != tx_ack_tgl_reg)
            begin
                tx_shift_reg <= tx_buf_reg;
                tx_ack_tgl_reg <= ~tx_ack_tgl_reg;
            end
            else
            begin
                tx_shift_reg <= `SSHP_IDLE_WORD;
            end
        end
    end

    // ==========================================
    // serial output, falling edge
    always_ff @(negedge sck)
    begin
        if (sck_rst)
        begin
            so_reg <= 1'b1;
        end
        else if (shift_en)
        begin
            so_reg <= tx_shift_reg[`SSHP_LAST_BIT - bit_cnt_reg];
        end
    end

    // ==========================================
    // outputs
    assign so = so_reg;
    assign so_oe = so_oe_reg;
    assign rx_data = rx_data_reg;
    assign rx_valid = rx_valid_reg;
    assign tx_ready = tx_ready_reg;
    assign paused = paused_reg;

endmodule // sshp_top

// >>> tb/spi_slave_hold_pause_tb.sv
// self-checking bench of the serial slave with pause control
`timescale 1ns/1ps
`include "sshp_defs.svh"
module spi_slave_hold_pause_tb;
    logic clk;
    logic srst;
    logic tx_load;
    wire logic sck;
    wire logic cs_n;
    wire logic hold_n;
    wire logic si;
    wire logic so;
    wire logic so_oe;
    wire logic rx_valid;
    wire logic tx_ready;
    wire logic paused;
    wire logic [`SSHP_WORD_W-1:0] rx_data;
    logic [7:0] n_rx = 8'h00;
    logic [`SSHP_WORD_W-1:0] tx_data;
    int fails = 0;
    int n_tests = 0;
    logic [7:0] row_si [4] = '{8'h5a, 8'h00, 8'hff, 8'h81};
    logic [7:0] row_tx [4] = '{8'ha5, 8'h3c, 8'h01, 8'h7e};
    sshp_top uut (.clk(clk), .srst(srst), .sck(sck), .cs_n(cs_n),
        .hold_n(hold_n), .si(si), .so(so), .so_oe(so_oe),
        .rx_data(rx_data), .rx_valid(rx_valid), .tx_data(tx_data),
        .tx_load(tx_load), .tx_ready(tx_ready), .paused(paused));
    sshp_master_model p (.sck(sck), .cs_n(cs_n), .hold_n(hold_n),
        .si(si), .so(so));
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // count received word pulses away from the launching edge
    always @(negedge clk)
    begin
        if (rx_valid === 1'b1)
            n_rx++;
    end
    // ====
    // compare and verdict
    task automatic chk8(input string nm, input logic [7:0] e,
        input logic [7:0] s);
        n_tests++;
        if (s !== e)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic chk1(input string nm, input logic e, input logic s);
        chk8(nm, {7'h00, e}, {7'h00, s});
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ====
    // frame: filler byte, then byte d with word t returned
    task automatic run_frame(input logic [7:0] d, input logic [7:0] t,
        input int mode);
        int i;
        logic [7:0] n0;
        i = 0;
        n0 = n_rx;
        @(negedge clk);
        while (tx_ready !== 1'b1 && i < 50)
        begin
            @(negedge clk);
            i++;
        end
        chk1("tx_ready", 1'b1, tx_ready);
        tx_data = t;
        tx_load = 1'b1;
        @(negedge clk);
        tx_load = 1'b0;
        chk1("tx_ready taken", 1'b0, tx_ready);
        // deselected clocks carry restart and reset across to the link side
        p.toggle(6);
        p.set_cs(1'b0);
        p.mo = 8'hc3;
        p.xfer(8);
        #100;
        p.mo = d;
        p.xfer(4);
        chk1("so_oe active", 1'b1, so_oe);
        if (mode > 0)
        begin
            p.set_hold(1'b0);
            if (mode > 1)
                p.set_cs(1'b1);
            p.toggle(4);
            chk1("paused", 1'b1, paused);
            chk1("so_oe held", 1'b0, so_oe);
            if (mode > 1)
                p.set_cs(1'b0);
            p.set_hold(1'b1);
        end
        p.xfer(4);
        p.set_cs(1'b1);
        chk8("rx_data", d, rx_data);
        chk8("so word", t, p.mi);
        chk8("rx words", 8'h02, n_rx - n0);
        $display("frame test mode %0d done", mode);
    endtask
    initial
    begin
        srst = 1'b1;
        tx_load = 1'b0;
        tx_data = 8'h00;
        fork
            repeat (4) @(negedge clk);
            p.toggle(8);
        join
        @(negedge clk);
        srst = 1'b0;
        repeat (2) @(negedge clk);
        chk1("so_oe", 1'b0, so_oe);
        chk1("paused", 1'b0, paused);
        chk1("rx_valid", 1'b0, rx_valid);
        chk8("rx_data", 8'h00, rx_data);
        chk1("tx_ready", 1'b1, tx_ready);
        $display("reset test done");
        repeat (4) @(negedge clk);
        for (int k = 0; k < 4; k++)
            run_frame(row_si[k], row_tx[k], 0);
        run_frame(8'h96, 8'h69, 1);
        run_frame(8'h4b, 8'hb4, 2);
        give_verdict;
    end
    initial
    begin
        #100000;
        fails++;
        give_verdict;
    end
endmodule // spi_slave_hold_pause_tb

// >>> tb/sshp_master_model.sv
// bus master model driving the serial link pins in mode 0
`timescale 1ns/1ps
module sshp_master_model
(
    // serial link pins
    output logic sck,
    output logic cs_n,
    output logic hold_n,
    output logic si,
    input wire logic so
);
    logic [7:0] mo = 8'h00;
    logic [7:0] mi = 8'h00;
    initial
    begin
        sck = 1'b0;
        cs_n = 1'b1;
        hold_n = 1'b1;
        si = 1'b1;
    end
    // ====
    // link tasks, clock stands low between them
    task automatic xfer(input int n);
        repeat (n)
        begin
            si = mo[7];
            mo = {mo[6:0], ~mo[7]};
            #6;
            sck = 1'b1;
            mi = {mi[6:0], so};
            #6;
            sck = 1'b0;
        end
        si = ~si;
    endtask
    // clock runs with data wiggling, as for another slave
    task automatic toggle(input int n);
        repeat (n)
        begin
            si = ~si;
            #6;
            sck = 1'b1;
            #6;
            sck = 1'b0;
        end
    endtask
    // step clear of the falling edge just made, clock still low
    task automatic set_hold(input logic v);
        #3;
        hold_n = v;
        #200;
    endtask
    task automatic set_cs(input logic v);
        #3;
        cs_n = v;
        #200;
    endtask
endmodule // sshp_master_model

// >>> tb/sshp_top_checker.sv
// timing assertions on the pins of the serial slave with pause
`timescale 1ns/1ps
`include "sshp_defs.svh"
module sshp_top_checker
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // watched pins
    input wire logic cs_n,
    input wire logic hold_n,
    input wire logic so,
    input wire logic so_oe,
    input wire logic [`SSHP_WORD_W-1:0] rx_data,
    input wire logic rx_valid,
    input wire logic tx_load,
    input wire logic tx_ready,
    input wire logic paused
);
    // ====
    // pause behaviour
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    AST_HOLD_OE: assert property (!hold_n [*8] |-> !so_oe)
        else $error("so driven while held");
    AST_PAUSED_OE: assert property (paused [*2] |-> !so_oe)
        else $error("so driven while paused");
    AST_RESUME: assert property ((hold_n && !cs_n) [*8] |-> !paused)
        else $error("still paused after release");
    AST_SO_FROZEN: assert property (!hold_n && $past(!hold_n) |-> $stable(so))
        else $error("so moved while held");
    AST_RX_FROZEN: assert property (!hold_n [*8] |-> !rx_valid && $stable(rx_data))
        else $error("word received while held");
    AST_TX_FROZEN: assert property ((!hold_n && !tx_load) [*8] |-> $stable(tx_ready))
        else $error("tx handshake moved while held");
    AST_DESEL_KEEP: assert property (paused && cs_n |=> paused)
        else $error("suspended sequence lost on deselect");
    AST_PAUSE_STAY: assert property (!hold_n [*8] |-> $stable(paused))
        else $error("pause state changed while held");
endmodule // sshp_top_checker

bind sshp_top sshp_top_checker u_chk
(
    .clk(clk), .srst(srst), .cs_n(cs_n), .hold_n(hold_n), .so(so),
    .so_oe(so_oe), .rx_data(rx_data), .rx_valid(rx_valid),
    .tx_load(tx_load), .tx_ready(tx_ready), .paused(paused)
);
